/* common/typec_attach_pkg.sv */
// Shared constants, types and register layout of the Type-C attach detector
// What this block does
// - Source, both open: watch both, no power
// - Source, Rd plus open: VBUS on, watch Rd
// - Source, Ra plus open: cable only, unpowered
// - Source, Ra plus Rd: VBUS, VCONN on Ra
// - Rd-Rd debug, Ra-Ra audio, either pin opening detaches audio only
// - Source drives current, classifies pins continuously
// - Advertise default, 1.5 A or 3 A
// - Below cable threshold means Ra
// - Above detach threshold means disconnection
// - Sink presents trimmed pulldown on both pins
// - Sink attaches only with VBUS present
// - Sink decodes advertised current from pullup
// - Firmware swaps dead-battery for trimmed pulldown
// - Source can disable dead-battery pulldown
// - One transmitter at a time, others released
// - Firmware sets transmit peak level
`default_nettype none
package typec_attach_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	// ****************************************
	// Control fields
	// ****************************************
	localparam int CTRL_ROLE_BIT = 0;
	localparam int CTRL_LEVEL_LSB = 1;
	localparam int CTRL_DBOFF_BIT = 3;
	localparam int CTRL_TRIM_BIT = 4;
	localparam int CTRL_TXP_LSB = 8;
	localparam int TXP_W = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0f1f;
	// ****************************************
	// Status fields
	// ****************************************
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_ORIENT_BIT = 7;
	localparam int STAT_CLS_A_LSB = 8;
	localparam int STAT_CLS_B_LSB = 10;
	localparam int STAT_SNKCUR_LSB = 12;
	localparam int STAT_VBUS_BIT = 14;
	localparam int STAT_VCONN_A_BIT = 15;
	localparam int STAT_VCONN_B_BIT = 16;
	// ****************************************
	// Interrupt fields
	// ****************************************
	localparam int IRQ_W = 3;
	localparam int IRQ_ATTACH_BIT = 0;
	localparam int IRQ_DETACH_BIT = 1;
	localparam int IRQ_CLASS_BIT = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		CLS_OPEN = 2'h0,
		CLS_RA = 2'h1,
		CLS_RD = 2'h2
	} cc_class_e;
	typedef enum logic [1:0] {
		CUR_DEFAULT = 2'h0,
		CUR_1P5 = 2'h1,
		CUR_3P0 = 2'h2
	} cur_level_e;
	typedef enum logic [6:0] {
		ST_UNATTACHED = 7'h01,
		ST_CABLE_ONLY = 7'h02,
		ST_SRC_ATTACHED = 7'h04,
		ST_SRC_CABLE = 7'h08,
		ST_DEBUG_ACC = 7'h10,
		ST_AUDIO_ACC = 7'h20,
		ST_SNK_ATTACHED = 7'h40
	} attach_state_e;
	// Raw comparator outputs of one configuration pin
	typedef struct packed {
		logic below_detach;
		logic below_cable;
		logic [1:0] snk_level;
	} pin_cmp_s;
	// Classified pin state
	typedef struct packed {
		cc_class_e cls;
		logic [1:0] snk_level;
	} pin_info_s;
	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
endpackage
`default_nettype wire

/* hw/cc_pin_classifier.sv */
// Per-pin synchroniser and three-way classifier of comparator outputs
`timescale 1ns/100ps
`default_nettype none
module cc_pin_classifier (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire typec_attach_pkg::pin_cmp_s cmp_raw,
	output var typec_attach_pkg::pin_info_s info
);
	import typec_attach_pkg::*;
	typedef struct packed {
		pin_cmp_s meta;
		pin_cmp_s sync;
		pin_info_s info;
	} cls_state_s;
	cls_state_s cur_ff;
	cls_state_s nxt_cur;
	// ****************************************
	// Classification
	// ****************************************
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.meta = cmp_raw;
		nxt_cur.sync = cur_ff.meta;
		nxt_cur.info.snk_level = cur_ff.sync.snk_level;
		if (cur_ff.sync.below_cable) begin
			nxt_cur.info.cls = CLS_RA;
		end else if (cur_ff.sync.below_detach) begin
			nxt_cur.info.cls = CLS_RD;
		end else begin
			nxt_cur.info.cls = CLS_OPEN;
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end
	assign info = cur_ff.info;
endmodule // cc_pin_classifier
`default_nettype wire

/* hw/typec_attach_detect.sv */
// Attach, orientation and role decision logic with its register file
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module typec_attach_detect #(
	parameter int TX_LEVEL_W = typec_attach_pkg::TXP_W
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire typec_attach_pkg::reg_req_s req,
	output logic [31:0] rd_data,
	output logic irq,
	input wire typec_attach_pkg::pin_cmp_s cmp_pin_a,
	input wire typec_attach_pkg::pin_cmp_s cmp_pin_b,
	input wire logic vbus_present,
	input wire logic tx_req,
	input wire logic tx_bit,
	output logic vbus_enable,
	output logic vconn_enable_a,
	output logic vconn_enable_b,
	output logic source_pin_current_a,
	output logic source_pin_current_b,
	output logic [1:0] source_current_level,
	output logic trimmed_sink_pulldown_a,
	output logic trimmed_sink_pulldown_b,
	output logic deadbattery_pulldown_off,
	output logic watch_pin_a,
	output logic watch_pin_b,
	output logic [TX_LEVEL_W-1:0] tx_peak_level,
	output logic config_pin_a_o,
	output logic config_pin_a_oe,
	output logic config_pin_b_o,
	output logic config_pin_b_oe
);
	import typec_attach_pkg::*;
	// ****************************************
	// Parameter check
	// ****************************************
	if (TX_LEVEL_W < 1 || TX_LEVEL_W > 8) begin : g_bad_width
		$error("TX_LEVEL_W must lie between 1 and 8");
	end
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic vbus_meta;
		logic vbus_sync;
		attach_state_e state;
		logic orient_b;
		cc_class_e prev_a;
		cc_class_e prev_b;
		logic [31:0] ctrl;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [31:0] rd_data;
		logic irq;
		logic vbus_en;
		logic vconn_a;
		logic vconn_b;
		logic cur_a;
		logic cur_b;
		logic [1:0] adv_level;
		logic [1:0] snk_cur;
		logic trim_a;
		logic trim_b;
		logic db_off;
		logic watch_a;
		logic watch_b;
		logic [TX_LEVEL_W-1:0] txp;
		logic a_o;
		logic a_oe;
		logic b_o;
		logic b_oe;
	} top_state_s;
	top_state_s cur_ff;
	top_state_s nxt_cur;
	pin_info_s pin_a;
	pin_info_s pin_b;
	// ****************************************
	// Pin classifiers
	// ****************************************
	cc_pin_classifier u_class_a (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.cmp_raw(cmp_pin_a),
		.info(pin_a)
	);
	cc_pin_classifier u_class_b (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.cmp_raw(cmp_pin_b),
		.info(pin_b)
	);
	function automatic logic has_partner(input attach_state_e s);
		has_partner = (s != ST_UNATTACHED) && (s != ST_CABLE_ONLY);
	endfunction
	// ****************************************
	// Decision and register logic
	// ****************************************
	logic role_sink;
	logic act_a;
	logic act_b;
	logic wr_ctrl;
	logic wr_irq;
	logic wr_mask;
	logic [IRQ_W-1:0] events;
	logic sig_pin_b;
	always_comb begin
		nxt_cur = cur_ff;
		role_sink = cur_ff.ctrl[CTRL_ROLE_BIT];
		act_a = pin_a.snk_level != 2'h0;
		act_b = pin_b.snk_level != 2'h0;
		wr_ctrl = req.wr && (req.addr == OFS_CTRL);
		wr_irq = req.wr && (req.addr == OFS_IRQ_STATUS);
		wr_mask = req.wr && (req.addr == OFS_IRQ_MASK);
		events = '0;
		sig_pin_b = 1'b0;
		nxt_cur.vbus_meta = vbus_present;
		nxt_cur.vbus_sync = cur_ff.vbus_meta;
		// Attach state from the two classes (ST_SRC_CABLE held while its Rd pin stays Rd), or in sink role from pullup levels and VBUS, every cycle
		nxt_cur.state = ST_UNATTACHED;
		nxt_cur.orient_b = 1'b0;
		if (role_sink) begin
			if (cur_ff.vbus_sync && (act_a || act_b)) begin
				nxt_cur.state = ST_SNK_ATTACHED;
				nxt_cur.orient_b = !act_a;
			end
		end else if (cur_ff.state == ST_SRC_CABLE && cur_ff.orient_b && pin_b.cls == CLS_RD) begin
			nxt_cur.state = ST_SRC_CABLE;
			nxt_cur.orient_b = 1'b1;
		end else if (cur_ff.state == ST_SRC_CABLE && !cur_ff.orient_b && pin_a.cls == CLS_RD) begin
			nxt_cur.state = ST_SRC_CABLE;
			nxt_cur.orient_b = 1'b0;
		end else begin
			case ({pin_a.cls, pin_b.cls})
				{CLS_RD, CLS_OPEN}: begin
					nxt_cur.state = ST_SRC_ATTACHED;
				end
				{CLS_OPEN, CLS_RD}: begin
					nxt_cur.state = ST_SRC_ATTACHED;
					nxt_cur.orient_b = 1'b1;
				end
				{CLS_RA, CLS_OPEN}: begin
					nxt_cur.state = ST_CABLE_ONLY;
				end
				{CLS_OPEN, CLS_RA}: begin
					nxt_cur.state = ST_CABLE_ONLY;
					nxt_cur.orient_b = 1'b1;
				end
				{CLS_RA, CLS_RD}: begin
					nxt_cur.state = ST_SRC_CABLE;
					nxt_cur.orient_b = 1'b1;
				end
				{CLS_RD, CLS_RA}: begin
					nxt_cur.state = ST_SRC_CABLE;
				end
				{CLS_RD, CLS_RD}: begin
					nxt_cur.state = ST_DEBUG_ACC;
				end
				{CLS_RA, CLS_RA}: begin
					nxt_cur.state = ST_AUDIO_ACC;
				end
				default: begin
					nxt_cur.state = ST_UNATTACHED;
				end
			endcase
		end
		// Power and watch outputs follow the new state
		nxt_cur.vbus_en = (nxt_cur.state == ST_SRC_ATTACHED) || (nxt_cur.state == ST_SRC_CABLE);
		nxt_cur.vconn_a = (nxt_cur.state == ST_SRC_CABLE) && nxt_cur.orient_b;
		nxt_cur.vconn_b = (nxt_cur.state == ST_SRC_CABLE) && !nxt_cur.orient_b;
		case (nxt_cur.state)
			ST_SRC_ATTACHED, ST_SRC_CABLE, ST_SNK_ATTACHED: begin
				nxt_cur.watch_a = !nxt_cur.orient_b;
				nxt_cur.watch_b = nxt_cur.orient_b;
			end
			default: begin
				nxt_cur.watch_a = 1'b1;
				nxt_cur.watch_b = 1'b1;
			end
		endcase
		// Source current on both pins except where VCONN drives
		nxt_cur.cur_a = !role_sink && !nxt_cur.vconn_a;
		nxt_cur.cur_b = !role_sink && !nxt_cur.vconn_b;
		nxt_cur.adv_level = cur_ff.ctrl[CTRL_LEVEL_LSB +: 2];
		if (nxt_cur.state == ST_SNK_ATTACHED) begin
			nxt_cur.snk_cur = nxt_cur.orient_b ? pin_b.snk_level : pin_a.snk_level;
		end else begin
			nxt_cur.snk_cur = 2'h0;
		end
		nxt_cur.trim_a = role_sink && cur_ff.ctrl[CTRL_TRIM_BIT];
		nxt_cur.trim_b = role_sink && cur_ff.ctrl[CTRL_TRIM_BIT];
		nxt_cur.db_off = (!role_sink && cur_ff.ctrl[CTRL_DBOFF_BIT])
			|| (role_sink && cur_ff.ctrl[CTRL_TRIM_BIT]);
		nxt_cur.txp = cur_ff.ctrl[CTRL_TXP_LSB +: TX_LEVEL_W];
		// Drive only the signalling pin, release both otherwise
		sig_pin_b = cur_ff.orient_b;
		nxt_cur.a_oe = tx_req && has_partner(cur_ff.state) && !sig_pin_b;
		nxt_cur.b_oe = tx_req && has_partner(cur_ff.state) && sig_pin_b;
		nxt_cur.a_o = nxt_cur.a_oe && tx_bit;
		nxt_cur.b_o = nxt_cur.b_oe && tx_bit;
		// Events
		nxt_cur.prev_a = pin_a.cls;
		nxt_cur.prev_b = pin_b.cls;
		events[IRQ_ATTACH_BIT] = has_partner(nxt_cur.state) && !has_partner(cur_ff.state);
		events[IRQ_DETACH_BIT] = !has_partner(nxt_cur.state) && has_partner(cur_ff.state);
		events[IRQ_CLASS_BIT] = (pin_a.cls != cur_ff.prev_a) || (pin_b.cls != cur_ff.prev_b);
		// Register writes; a new event wins over its clear
		if (wr_ctrl) begin
			nxt_cur.ctrl = req.wdata & CTRL_WMASK;
		end
		if (wr_mask) begin
			nxt_cur.irq_mask = req.wdata[IRQ_W-1:0];
		end
		if (wr_irq) begin
			nxt_cur.irq_stat = (cur_ff.irq_stat & ~req.wdata[IRQ_W-1:0]) | events;
		end else begin
			nxt_cur.irq_stat = cur_ff.irq_stat | events;
		end
		nxt_cur.irq = |(nxt_cur.irq_stat & nxt_cur.irq_mask);
		// Read data stand for one cycle only
		nxt_cur.rd_data = 32'h0000_0000;
		if (req.rd) begin
			if (req.addr == OFS_CTRL) begin
				nxt_cur.rd_data = cur_ff.ctrl;
			end else if (req.addr == OFS_STATUS) begin
				nxt_cur.rd_data[STAT_STATE_LSB +: 7] = cur_ff.state;
				nxt_cur.rd_data[STAT_ORIENT_BIT] = cur_ff.orient_b;
				nxt_cur.rd_data[STAT_CLS_A_LSB +: 2] = pin_a.cls;
				nxt_cur.rd_data[STAT_CLS_B_LSB +: 2] = pin_b.cls;
				nxt_cur.rd_data[STAT_SNKCUR_LSB +: 2] = cur_ff.snk_cur;
				nxt_cur.rd_data[STAT_VBUS_BIT] = cur_ff.vbus_en;
				nxt_cur.rd_data[STAT_VCONN_A_BIT] = cur_ff.vconn_a;
				nxt_cur.rd_data[STAT_VCONN_B_BIT] = cur_ff.vconn_b;
			end else if (req.addr == OFS_IRQ_STATUS) begin
				nxt_cur.rd_data[IRQ_W-1:0] = cur_ff.irq_stat;
			end else if (req.addr == OFS_IRQ_MASK) begin
				nxt_cur.rd_data[IRQ_W-1:0] = cur_ff.irq_mask;
			end else begin
				nxt_cur.rd_data = 32'h0000_0000;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cur_ff <= '0;
			cur_ff.state <= ST_UNATTACHED;
			cur_ff.ctrl <= CTRL_RESET;
			cur_ff.irq_mask <= IRQ_MASK_RESET;
		end else begin
			cur_ff <= nxt_cur;
		end
	end
	// ****************************************
	// Outputs
	// ****************************************
	assign rd_data = cur_ff.rd_data;
	assign irq = cur_ff.irq;
	assign vbus_enable = cur_ff.vbus_en;
	assign vconn_enable_a = cur_ff.vconn_a;
	assign vconn_enable_b = cur_ff.vconn_b;
	assign source_pin_current_a = cur_ff.cur_a;
	assign source_pin_current_b = cur_ff.cur_b;
	assign source_current_level = cur_ff.adv_level;
	assign trimmed_sink_pulldown_a = cur_ff.trim_a;
	assign trimmed_sink_pulldown_b = cur_ff.trim_b;
	assign deadbattery_pulldown_off = cur_ff.db_off;
	assign watch_pin_a = cur_ff.watch_a;
	assign watch_pin_b = cur_ff.watch_b;
	assign tx_peak_level = cur_ff.txp;
	assign config_pin_a_o = cur_ff.a_o;
	assign config_pin_a_oe = cur_ff.a_oe;
	assign config_pin_b_o = cur_ff.b_o;
	assign config_pin_b_oe = cur_ff.b_oe;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_open_unpowered;
		(!role_sink && pin_a.cls == CLS_OPEN && pin_b.cls == CLS_OPEN)
			|=> (!vbus_enable && !vconn_enable_a && !vconn_enable_b && watch_pin_a && watch_pin_b);
	endproperty
	a_open_unpowered: assert property (p_open_unpowered) else $error("power applied with pins open");
	property p_rd_open;
		(!role_sink && pin_a.cls == CLS_RD && pin_b.cls == CLS_OPEN
			&& cur_ff.state != ST_SRC_CABLE)
			|=> (vbus_enable && !vconn_enable_b && watch_pin_a && !watch_pin_b);
	endproperty
	a_rd_open: assert property (p_rd_open) else $error("sink on pin a not served");
	property p_cable_only;
		(!role_sink && pin_a.cls == CLS_OPEN && pin_b.cls == CLS_RA)
			|=> (!vbus_enable && !vconn_enable_a && !vconn_enable_b && watch_pin_a && watch_pin_b);
	endproperty
	a_cable_only: assert property (p_cable_only) else $error("cable only state wrong");
	property p_cable_sink;
		(!role_sink && pin_a.cls == CLS_RA && pin_b.cls == CLS_RD)
			|=> (vbus_enable && vconn_enable_a && !vconn_enable_b && !watch_pin_a && watch_pin_b);
	endproperty
	a_cable_sink: assert property (p_cable_sink) else $error("cable with sink state wrong");
	property p_debug_acc;
		(!role_sink && pin_a.cls == CLS_RD && pin_b.cls == CLS_RD
			&& cur_ff.state != ST_SRC_CABLE)
			|=> (cur_ff.state == ST_DEBUG_ACC && watch_pin_a && watch_pin_b);
	endproperty
	a_debug_acc: assert property (p_debug_acc) else $error("debug accessory not reported");
	property p_src_current;
		!role_sink |=> (source_pin_current_a || vconn_enable_a) && (source_pin_current_b || vconn_enable_b);
	endproperty
	a_src_current: assert property (p_src_current) else $error("source current missing");
	property p_sink_vbus;
		(role_sink && !cur_ff.vbus_sync) |=> (cur_ff.state != ST_SNK_ATTACHED) ##1 !config_pin_a_oe;
	endproperty
	a_sink_vbus: assert property (p_sink_vbus) else $error("sink attached without VBUS");
	property p_sink_level;
		(role_sink && cur_ff.vbus_sync && act_a) |=> (source_current_level == $past(cur_ff.ctrl[2:1])
			&& cur_ff.snk_cur == $past(pin_a.snk_level));
	endproperty
	a_sink_level: assert property (p_sink_level) else $error("advertised current not decoded");
	property p_one_driver;
		!(config_pin_a_oe && config_pin_b_oe) and (!tx_req |=> !config_pin_a_oe && !config_pin_b_oe);
	endproperty
	a_one_driver: assert property (p_one_driver) else $error("pin driven out of turn");
	property p_txp_write;
		(req.wr && req.addr == OFS_CTRL) |=> ##1 (tx_peak_level == $past(req.wdata[CTRL_TXP_LSB +: TX_LEVEL_W], 2));
	endproperty
	a_txp_write: assert property (p_txp_write) else $error("peak level not taken");
	property p_db_off;
		(!role_sink && cur_ff.ctrl[CTRL_DBOFF_BIT]) |=> deadbattery_pulldown_off;
	endproperty
	a_db_off: assert property (p_db_off) else $error("dead-battery pulldown not released");
	property p_audio_acc;
		(!role_sink && pin_a.cls == CLS_RA && pin_b.cls == CLS_RA)
			|=> (cur_ff.state == ST_AUDIO_ACC && !vbus_enable && watch_pin_a && watch_pin_b);
	endproperty
	a_audio_acc: assert property (p_audio_acc) else $error("audio accessory not reported");
	property p_sink_trim;
		(role_sink && cur_ff.ctrl[CTRL_TRIM_BIT])
			|=> (trimmed_sink_pulldown_a && trimmed_sink_pulldown_b && !source_pin_current_a);
	endproperty
	a_sink_trim: assert property (p_sink_trim) else $error("trimmed pulldown missing");
	property p_class_event;
		(pin_a.cls != cur_ff.prev_a || pin_b.cls != cur_ff.prev_b)
			|=> cur_ff.irq_stat[IRQ_CLASS_BIT];
	endproperty
	a_class_event: assert property (p_class_event) else $error("class change not flagged");
	property p_detach_release;
		(!role_sink && pin_a.cls == CLS_OPEN && pin_b.cls == CLS_OPEN
			&& cur_ff.state == ST_SRC_ATTACHED)
			|=> (!vbus_enable && cur_ff.irq_stat[IRQ_DETACH_BIT]);
	endproperty
	a_detach_release: assert property (p_detach_release) else $error("detach not registered");
endmodule // typec_attach_detect
`default_nettype wire

/* testbench/cc_far_port.sv */
// Far-end Type-C port model: loads or pullups on both pins, VBUS supply
`timescale 1ns/100ps
`default_nettype none
module cc_far_port (
	input wire logic [1:0] load_a,
	input wire logic [1:0] load_b,
	input wire logic [1:0] pull_a,
	input wire logic [1:0] pull_b,
	input wire logic supply_vbus,
	output var typec_attach_pkg::pin_cmp_s cmp_a,
	output var typec_attach_pkg::pin_cmp_s cmp_b,
	output logic vbus_present,
	output logic far_oe
);
	import typec_attach_pkg::*;
	// ****************************************
	// Comparator view of each pin
	// ****************************************
	function automatic pin_cmp_s pin_view(input logic [1:0] ld, input logic [1:0] pu);
		pin_cmp_s v;
		v.below_cable = (ld == CLS_RA);
		v.below_detach = (ld != CLS_OPEN);
		v.snk_level = pu;
		return v;
	endfunction
	assign cmp_a = pin_view(load_a, pull_a);
	assign cmp_b = pin_view(load_b, pull_b);
	// VBUS only while the far end sources
	assign vbus_present = supply_vbus;
	// Far end stays released
	assign far_oe = 1'b0;
endmodule // cc_far_port
`default_nettype wire

/* testbench/typec_attach_detect_test.sv */
// Self-checking bench of the Type-C attach detector
`timescale 1ns/100ps
`default_nettype none
module typec_attach_detect_test;
	import typec_attach_pkg::*;
	typedef struct packed {
		logic [6:0] st;
		logic vb;
		logic va;
		logic vc_b;
		logic wa;
		logic wb;
	} exp_s;
	logic ref_clk, resetn, irq, vbus_present, tx_req, tx_bit, supply_vbus, far_oe;
	logic vbus_enable, vconn_enable_a, vconn_enable_b, spc_a, spc_b, trim_a, trim_b, db_off;
	logic watch_pin_a, watch_pin_b, cpa_o, cpa_oe, cpb_o, cpb_oe, dbo;
	logic [1:0] source_current_level, load_a, load_b, pull_a, pull_b, lvl;
	logic [3:0] tx_peak_level, txp;
	logic [31:0] rd_data, rv;
	reg_req_s req;
	pin_cmp_s cmp_a, cmp_b;
	exp_s e;
	int fails, checked;

	typec_attach_detect dut (.ref_clk(ref_clk), .resetn(resetn), .req(req), .rd_data(rd_data),
		.irq(irq), .cmp_pin_a(cmp_a), .cmp_pin_b(cmp_b), .vbus_present(vbus_present),
		.tx_req(tx_req), .tx_bit(tx_bit), .vbus_enable(vbus_enable),
		.vconn_enable_a(vconn_enable_a), .vconn_enable_b(vconn_enable_b),
		.source_pin_current_a(spc_a), .source_pin_current_b(spc_b),
		.source_current_level(source_current_level), .trimmed_sink_pulldown_a(trim_a),
		.trimmed_sink_pulldown_b(trim_b), .deadbattery_pulldown_off(db_off),
		.watch_pin_a(watch_pin_a), .watch_pin_b(watch_pin_b), .tx_peak_level(tx_peak_level),
		.config_pin_a_o(cpa_o), .config_pin_a_oe(cpa_oe), .config_pin_b_o(cpb_o),
		.config_pin_b_oe(cpb_oe));
	cc_far_port far (.load_a(load_a), .load_b(load_b), .pull_a(pull_a), .pull_b(pull_b),
		.supply_vbus(supply_vbus), .cmp_a(cmp_a), .cmp_b(cmp_b),
		.vbus_present(vbus_present), .far_oe(far_oe));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// ****************************************
	// Helpers
	// ****************************************
	function automatic exp_s src_exp(input logic [1:0] a, input logic [1:0] b);
		exp_s x;
		x = {7'h01, 5'b00011};
		if (a == CLS_RD && b == CLS_RD) x.st = 7'h10;
		else if (a == CLS_RA && b == CLS_RA) x.st = 7'h20;
		else if (a == CLS_RD || b == CLS_RD) begin
			x.vb = 1'b1;
			x.va = (a == CLS_RA);
			x.vc_b = (b == CLS_RA);
			x.wa = (a == CLS_RD);
			x.wb = (b == CLS_RD);
			x.st = (a == CLS_RA || b == CLS_RA) ? 7'h08 : 7'h04;
		end else if (a == CLS_RA || b == CLS_RA) x.st = 7'h02;
		return x;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			fails++;
			$display("BAD at %0t: saw %h, want %h", $time, seen, want);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge ref_clk);
		req.rd <= 1'b0;
		@(negedge ref_clk);
		d = rd_data;
	endtask
	task automatic set_far(input logic [1:0] a, input logic [1:0] b);
		@(posedge ref_clk);
		load_a <= a;
		load_b <= b;
		wait_n(8);
	endtask
	task automatic tx_try(input logic att, input logic on_b);
		logic b;
		b = 1'($urandom());
		@(posedge ref_clk);
		tx_req <= 1'b1;
		tx_bit <= b;
		wait_n(2);
		@(negedge ref_clk);
		check({28'h0, cpa_oe, cpa_o, cpb_oe, cpb_o},
			{28'h0, att & ~on_b, att & ~on_b & b, att & on_b, att & on_b & b});
		check({31'h0, far_oe & cpb_oe}, 32'h0);
		@(posedge ref_clk);
		tx_req <= 1'b0;
		wait_n(2);
		@(negedge ref_clk);
		check({30'h0, cpa_oe, cpb_oe}, 32'h0);
	endtask
	task automatic results;
		$display("counts: %0d checked, %0d failed", checked, fails);
		if (fails == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		#1000000;
		fails++;
		$display("BAD at %0t: watchdog expired", $time);
		results();
	end
	initial begin
		req = '0;
		resetn = 1'b0;
		tx_req = 1'b0;
		tx_bit = 1'b0;
		supply_vbus = 1'b0;
		{load_a, load_b, pull_a, pull_b} = 8'h00;
		fails = 0;
		checked = 0;
		void'($urandom(32'h9b2d));
		wait_n(16);
		resetn <= 1'b1;
		wait_n(4);
		reg_rd(OFS_CTRL, rv);
		check(rv, CTRL_RESET);
		reg_rd(OFS_IRQ_MASK, rv);
		check(rv, {29'h0, IRQ_MASK_RESET});
		reg_rd(OFS_STATUS, rv);
		check({25'h0, rv[6:0]}, {25'h0, ST_UNATTACHED});
		reg_wr(8'h10, 32'hffff_ffff);
		reg_rd(8'h10, rv);
		check(rv, 32'h0);
		reg_wr(OFS_CTRL, 32'hffff_ffff);
		reg_rd(OFS_CTRL, rv);
		check(rv, CTRL_WMASK);
		check({28'h0, tx_peak_level}, 32'hf);
		reg_wr(OFS_CTRL, 32'h0);
		$display("test registers done");
		reg_wr(OFS_IRQ_MASK, 32'h1);
		for (int i = 0; i < 9; i++) begin
			lvl = 2'($urandom_range(2, 0));
			txp = 4'($urandom());
			dbo = 1'($urandom());
			reg_wr(OFS_CTRL, {20'h0, txp, 4'h0, dbo, lvl, 1'b0});
			set_far(2'(i / 3), 2'(i % 3));
			e = src_exp(load_a, load_b);
			check({27'h0, vbus_enable, vconn_enable_a, vconn_enable_b, watch_pin_a, watch_pin_b},
				{27'h0, e[4:0]});
			check({30'h0, spc_a, spc_b}, {30'h0, ~e.va, ~e.vc_b});
			check({28'h0, source_current_level, db_off, trim_a}, {28'h0, lvl, dbo, 1'b0});
			check({28'h0, tx_peak_level}, {28'h0, txp});
			reg_rd(OFS_STATUS, rv);
			check({25'h0, rv[6:0]}, {25'h0, e.st});
			if (e.vb || i == 0) check({31'h0, irq}, {31'h0, e.vb});
			if (e.vb) begin
				reg_wr(OFS_IRQ_MASK, 32'h0);
				wait_n(2);
				check({31'h0, irq}, 32'h0);
				reg_wr(OFS_IRQ_MASK, 32'h1);
			end
			reg_wr(OFS_IRQ_STATUS, 32'h7);
			wait_n(2);
			check({31'h0, irq}, 32'h0);
			if (e.st == ST_SRC_CABLE) begin
				set_far(load_a == CLS_RA ? CLS_OPEN : load_a, load_b == CLS_RA ? CLS_OPEN : load_b);
				check({27'h0, vbus_enable, vconn_enable_a, vconn_enable_b, watch_pin_a, watch_pin_b},
					{27'h0, e[4:0]});
			end
			if (e.vb) tx_try(1'b1, load_b == CLS_RD);
			set_far(CLS_OPEN, CLS_OPEN);
			check({29'h0, vbus_enable, watch_pin_a, watch_pin_b}, 32'h3);
			reg_rd(OFS_IRQ_STATUS, rv);
			check({29'h0, rv[2:0]}, {29'h0, i != 0, e.st > 7'h02, 1'b0});
			reg_wr(OFS_IRQ_STATUS, 32'h7);
		end
		tx_try(1'b0, 1'b0);
		$display("test source table done");
		reg_wr(OFS_CTRL, 32'h11);
		lvl = 2'($urandom_range(3, 1));
		@(posedge ref_clk);
		pull_b <= lvl;
		wait_n(8);
		reg_rd(OFS_STATUS, rv);
		check({31'h0, rv[6]}, 32'h0);
		check({27'h0, vbus_enable, trim_a, trim_b, db_off, spc_a}, 32'h0e);
		@(posedge ref_clk);
		supply_vbus <= 1'b1;
		wait_n(8);
		reg_rd(OFS_STATUS, rv);
		check({18'h0, rv[13:0]}, {18'h0, lvl, 4'h0, 1'b1, 7'h40});
		@(posedge ref_clk);
		{pull_a, pull_b} <= {lvl, 2'h0};
		wait_n(8);
		reg_rd(OFS_STATUS, rv);
		check({18'h0, rv[13:0]}, {18'h0, lvl, 4'h0, 1'b0, 7'h40});
		reg_wr(OFS_CTRL, 32'h1);
		wait_n(2);
		check({30'h0, trim_a, db_off}, 32'h0);
		$display("test sink done");
		results();
	end
endmodule // typec_attach_detect_test
`default_nettype wire
